// [core/crf_core_state.sv]
// Purpose: Architectural registers, flag register and flag update logic.
// Assumes: An external decoder drives operation, operands and results.
// Notes:   Arithmetic here only derives flags and decimal corrections.
`timescale 1ns/100ps
`default_nettype none
`include "crf_map.svh"
module crf_core_state (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // General register access
  input  wire logic [3:0]           i_rd_sel,
  input  wire logic                 i_rd_word,
  output logic      [15:0]          o_rd_data,
  input  wire logic [2:0]           i_addr_sel,
  output logic      [15:0]          o_addr,
  input  wire logic                 i_wr_en,
  input  wire logic [3:0]           i_wr_sel,
  input  wire logic                 i_wr_word,
  input  wire logic [15:0]          i_wr_data,
  output logic      [15:0]          o_stack_top,
  input  wire logic                 i_word_access,
  input  wire logic [15:0]          i_mem_addr,
  output logic      [15:0]          o_mem_addr,
  // Instruction pointer
  input  wire logic [15:0]          i_vector,
  input  wire logic                 i_ip_load,
  input  wire logic [15:0]          i_ip_value,
  input  wire logic                 i_ip_step,
  output logic      [15:0]          o_ip,
  // Flag update
  input  wire logic                 i_op_valid,
  input  wire crf_pkg::crf_op_t     i_op,
  input  wire logic [15:0]          i_opa,
  input  wire logic [15:0]          i_opb,
  input  wire logic                 i_shift_out,
  input  wire logic [2:0]           i_bit_sel,
  output logic      [7:0]           o_dec_result,
  output logic      [7:0]           o_flags,
  output logic      [15:0]          o_flag_push,
  output logic                      o_op_done,
  // Interrupts and branches
  input  wire logic                 i_irq,
  input  wire logic                 i_nmi,
  input  wire logic                 i_int_enter,
  output logic                      o_int_take,
  input  wire crf_pkg::crf_cc_t     i_cc,
  output logic                      o_cc_true
);
  logic [15:0]           regs   [8];
  logic [7:0]            flags_r;
  logic                  mask_r;
  logic [6:0]            low_flags_r;
  logic [7:0]            flags_nxt;
  logic [15:0]           ip_r;
  logic [7:0]            dec_r;
  logic [7:0]            dec_nxt;
  logic [1:0]            busy_r;
  crf_pkg::crf_state_t   state_r;
  logic                  done_r;

  // Byte select: bit 3 picks low byte, bits 2:0 pick the word
  for (genvar g = 0; g < 8; g++) begin : g_regs
    logic we_hi;
    logic we_lo;
    assign we_hi = i_wr_en && (i_wr_sel[2:0] == 3'(g)) && (i_wr_word || !i_wr_sel[3]);
    assign we_lo = i_wr_en && (i_wr_sel[2:0] == 3'(g)) && (i_wr_word || i_wr_sel[3]);
    crf_word_reg u_reg (
      .i_clk   (i_clk),
      .i_we_hi (we_hi),
      .i_we_lo (we_lo),
      .i_wdata (i_wr_word ? i_wr_data : {i_wr_data[7:0], i_wr_data[7:0]}),
      .o_q     (regs[g])
    );
  end

  always_comb begin
    if (i_rd_word) begin
      o_rd_data = regs[i_rd_sel[2:0]]; // RULE_01
    end else if (i_rd_sel[3]) begin
      o_rd_data = {8'h00, regs[i_rd_sel[2:0]][7:0]};
    end else begin
      o_rd_data = {8'h00, regs[i_rd_sel[2:0]][15:8]};
    end
  end

  assign o_addr      = regs[i_addr_sel]; // RULE_02 RULE_23
  assign o_stack_top = regs[`CRF_STACK_IDX]; // RULE_03
  // Odd word addresses silently drop to the even one below
  assign o_mem_addr  = i_word_access ? {i_mem_addr[15:1], 1'b0} : i_mem_addr; // RULE_18

  // Instruction pointer: bit 0 is never stored as one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ip_r <= 16'h0000;
    end else if (state_r == crf_pkg::CRF_ST_RESET) begin
      ip_r <= {i_vector[15:1], 1'b0}; // RULE_16 RULE_04
    end else if (i_ip_load) begin
      ip_r <= {i_ip_value[15:1], 1'b0}; // RULE_04 RULE_18
    end else if (i_ip_step) begin
      ip_r <= ip_r + 16'h0002; // RULE_04
    end
  end
  assign o_ip = ip_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= crf_pkg::CRF_ST_RESET;
    end else begin
      state_r <= crf_pkg::CRF_ST_RUN;
    end
  end

  // Flag derivation
  logic [8:0]  sum8;
  logic [4:0]  sum4;
  logic [16:0] sum16;
  logic [12:0] sum12;
  logic        cin;
  logic [7:0]  res8;
  logic [15:0] res16;
  logic [7:0]  corr;
  logic        c_out;
  logic        h_out;
  logic        v_out;
  logic        is_sub;

  always_comb begin
    corr   = 8'h00;
    c_out  = 1'b0;
    unique case (i_op)
      crf_pkg::CRF_OP_ADDXB, crf_pkg::CRF_OP_SUBXB: cin = flags_r[`CRF_FLAG_CARRY];
      default:                                      cin = 1'b0;
    endcase
    unique case (i_op)
      crf_pkg::CRF_OP_SUBB, crf_pkg::CRF_OP_SUBXB, crf_pkg::CRF_OP_CMPB,
      crf_pkg::CRF_OP_NEGB, crf_pkg::CRF_OP_SUBW, crf_pkg::CRF_OP_CMPW: is_sub = 1'b1;
      default:                                                          is_sub = 1'b0;
    endcase
    if (i_op == crf_pkg::CRF_OP_NEGB) begin
      sum8 = {1'b0, 8'h00} - {1'b0, i_opa[7:0]};
      sum4 = {1'b0, 4'h0} - {1'b0, i_opa[3:0]};
    end else if (is_sub) begin
      sum8 = {1'b0, i_opa[7:0]} - {1'b0, i_opb[7:0]} - {8'h00, cin};
      sum4 = {1'b0, i_opa[3:0]} - {1'b0, i_opb[3:0]} - {4'h0, cin};
    end else begin
      sum8 = {1'b0, i_opa[7:0]} + {1'b0, i_opb[7:0]} + {8'h00, cin};
      sum4 = {1'b0, i_opa[3:0]} + {1'b0, i_opb[3:0]} + {4'h0, cin};
    end
    if (is_sub) begin
      sum16 = {1'b0, i_opa} - {1'b0, i_opb};
      sum12 = {1'b0, i_opa[11:0]} - {1'b0, i_opb[11:0]};
    end else begin
      sum16 = {1'b0, i_opa} + {1'b0, i_opb};
      sum12 = {1'b0, i_opa[11:0]} + {1'b0, i_opb[11:0]};
    end
    res8  = sum8[7:0];
    res16 = sum16[15:0];
    // Decimal adjust: correct each nibble as a packed decimal digit
    if (i_op == crf_pkg::CRF_OP_DAA) begin
      if (flags_r[`CRF_FLAG_HALF] || (i_opa[3:0] > 4'h9)) begin
        corr[3:0] = 4'h6; // RULE_21
      end
      if (flags_r[`CRF_FLAG_CARRY] || (i_opa[7:0] > 8'h99)) begin
        corr[7:4] = 4'h6; // RULE_21
        c_out     = 1'b1;
      end
    end else if (i_op == crf_pkg::CRF_OP_DAS) begin
      if (flags_r[`CRF_FLAG_HALF]) begin
        // A low-digit borrow alone still borrows through the upper digit
        corr      = 8'hFA; // RULE_21
      end
      if (flags_r[`CRF_FLAG_CARRY]) begin
        corr[7:4] = flags_r[`CRF_FLAG_HALF] ? 4'h9 : 4'hA; // RULE_21
        c_out     = 1'b1;
      end
    end
  end

  assign h_out = sum4[4];
  assign v_out = is_sub ? ((i_opa[7] ^ i_opb[7]) & (i_opa[7] ^ res8[7]))
                        : (~(i_opa[7] ^ i_opb[7]) & (i_opa[7] ^ res8[7]));

  always_comb begin
    logic [7:0] lres;
    logic       wv;
    lres      = 8'h00;
    wv        = 1'b0;
    flags_nxt = flags_r; // RULE_25
    dec_nxt   = dec_r;
    unique case (i_op)
      crf_pkg::CRF_OP_ADDB, crf_pkg::CRF_OP_ADDXB, crf_pkg::CRF_OP_SUBB,
      crf_pkg::CRF_OP_SUBXB, crf_pkg::CRF_OP_CMPB: begin
        flags_nxt[`CRF_FLAG_HALF]  = h_out; // RULE_08
        flags_nxt[`CRF_FLAG_NEG]   = res8[7]; // RULE_10
        flags_nxt[`CRF_FLAG_ZERO]  = (res8 == 8'h00); // RULE_11
        flags_nxt[`CRF_FLAG_OVF]   = v_out; // RULE_12
        flags_nxt[`CRF_FLAG_CARRY] = sum8[8]; // RULE_13
      end
      crf_pkg::CRF_OP_NEGB: begin
        flags_nxt[`CRF_FLAG_HALF]  = h_out; // RULE_08
        flags_nxt[`CRF_FLAG_NEG]   = res8[7]; // RULE_10
        flags_nxt[`CRF_FLAG_ZERO]  = (res8 == 8'h00); // RULE_11
        flags_nxt[`CRF_FLAG_OVF]   = (i_opa[7:0] == 8'h80); // RULE_12
        flags_nxt[`CRF_FLAG_CARRY] = sum8[8]; // RULE_13
      end
      crf_pkg::CRF_OP_ADDW, crf_pkg::CRF_OP_SUBW, crf_pkg::CRF_OP_CMPW: begin
        wv = (i_op == crf_pkg::CRF_OP_ADDW)
             ? (~(i_opa[15] ^ i_opb[15]) & (i_opa[15] ^ res16[15]))
             : ((i_opa[15] ^ i_opb[15]) & (i_opa[15] ^ res16[15]));
        flags_nxt[`CRF_FLAG_HALF]  = sum12[12]; // RULE_09
        flags_nxt[`CRF_FLAG_NEG]   = res16[15]; // RULE_10
        flags_nxt[`CRF_FLAG_ZERO]  = (res16 == 16'h0000); // RULE_11
        flags_nxt[`CRF_FLAG_OVF]   = wv; // RULE_12
        flags_nxt[`CRF_FLAG_CARRY] = sum16[16]; // RULE_13
      end
      crf_pkg::CRF_OP_ANDB, crf_pkg::CRF_OP_ORB, crf_pkg::CRF_OP_XORB,
      crf_pkg::CRF_OP_MOVB: begin
        unique case (i_op)
          crf_pkg::CRF_OP_ANDB: lres = i_opa[7:0] & i_opb[7:0];
          crf_pkg::CRF_OP_ORB:  lres = i_opa[7:0] | i_opb[7:0];
          crf_pkg::CRF_OP_XORB: lres = i_opa[7:0] ^ i_opb[7:0];
          default:              lres = i_opa[7:0];
        endcase
        flags_nxt[`CRF_FLAG_NEG]  = lres[7]; // RULE_10
        flags_nxt[`CRF_FLAG_ZERO] = (lres == 8'h00); // RULE_11
        flags_nxt[`CRF_FLAG_OVF]  = 1'b0;
      end
      crf_pkg::CRF_OP_MOVW: begin
        flags_nxt[`CRF_FLAG_NEG]  = i_opa[15]; // RULE_10 RULE_22
        flags_nxt[`CRF_FLAG_ZERO] = (i_opa == 16'h0000); // RULE_11
        flags_nxt[`CRF_FLAG_OVF]  = 1'b0;
      end
      crf_pkg::CRF_OP_SHLB, crf_pkg::CRF_OP_SHRB: begin
        lres = (i_op == crf_pkg::CRF_OP_SHLB) ? {i_opa[6:0], 1'b0} : {1'b0, i_opa[7:1]};
        flags_nxt[`CRF_FLAG_NEG]   = lres[7]; // RULE_10
        flags_nxt[`CRF_FLAG_ZERO]  = (lres == 8'h00); // RULE_11
        flags_nxt[`CRF_FLAG_OVF]   = 1'b0;
        flags_nxt[`CRF_FLAG_CARRY] = i_shift_out; // RULE_13
      end
      crf_pkg::CRF_OP_BLD: begin
        flags_nxt[`CRF_FLAG_CARRY] = i_opa[i_bit_sel]; // RULE_13 RULE_20
      end
      crf_pkg::CRF_OP_FLDC:  flags_nxt = i_opa[7:0]; // RULE_14 RULE_07
      crf_pkg::CRF_OP_FPOP:  flags_nxt = i_opa[15:8]; // RULE_19
      crf_pkg::CRF_OP_FAND:  flags_nxt = flags_r & i_opa[7:0]; // RULE_14 RULE_07
      crf_pkg::CRF_OP_FOR:   flags_nxt = flags_r | i_opa[7:0]; // RULE_14 RULE_07
      crf_pkg::CRF_OP_FXOR:  flags_nxt = flags_r ^ i_opa[7:0]; // RULE_14 RULE_07
      crf_pkg::CRF_OP_DAA, crf_pkg::CRF_OP_DAS: begin
        lres = i_opa[7:0] + corr;
        dec_nxt = lres; // RULE_21
        flags_nxt[`CRF_FLAG_NEG]   = lres[7]; // RULE_10
        flags_nxt[`CRF_FLAG_ZERO]  = (lres == 8'h00); // RULE_11
        flags_nxt[`CRF_FLAG_CARRY] = c_out; // RULE_13
      end
      default: flags_nxt = flags_r; // RULE_25
    endcase
    if (i_int_enter) begin
      flags_nxt[`CRF_FLAG_MASK] = 1'b1; // RULE_06
    end
  end

  // Only the mask bit has a reset value; other flags stay as they were
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_r <= `CRF_MASK_RESET; // RULE_06 RULE_16
    end else if (i_op_valid || i_int_enter) begin
      mask_r <= flags_nxt[`CRF_FLAG_MASK];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_op_valid) begin
      low_flags_r <= flags_nxt[6:0]; // RULE_25
    end
  end
  assign flags_r = {mask_r, low_flags_r};

  always_ff @(posedge i_clk) begin
    if (i_op_valid) begin
      dec_r <= dec_nxt;
    end
  end

  // Add and subtract completion: three cycles at this clock stays within the budget
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_r <= 2'h0;
      done_r <= 1'b0;
    end else if (i_op_valid && busy_r == 2'h0) begin
      busy_r <= 2'(`CRF_ADD_CYCLES - 2);
      done_r <= 1'b0;
    end else if (busy_r != 2'h0) begin
      busy_r <= busy_r - 2'h1;
      done_r <= (busy_r == 2'h1); // RULE_24
    end else begin
      done_r <= 1'b0;
    end
  end

  assign o_op_done    = done_r;
  assign o_flags      = flags_r;
  assign o_dec_result = dec_r;
  assign o_flag_push  = {flags_r, flags_r}; // RULE_19
  assign o_int_take   = i_nmi || (i_irq && !flags_r[`CRF_FLAG_MASK]); // RULE_05

  // Branch conditions see only negative, zero, overflow and carry
  always_comb begin
    logic n;
    logic z;
    logic v;
    logic c;
    n = flags_r[`CRF_FLAG_NEG];
    z = flags_r[`CRF_FLAG_ZERO];
    v = flags_r[`CRF_FLAG_OVF];
    c = flags_r[`CRF_FLAG_CARRY];
    unique case (i_cc)
      crf_pkg::CRF_CC_ALWAYS: o_cc_true = 1'b1;
      crf_pkg::CRF_CC_NEVER:  o_cc_true = 1'b0;
      crf_pkg::CRF_CC_CS:     o_cc_true = c; // RULE_15
      crf_pkg::CRF_CC_CC:     o_cc_true = !c;
      crf_pkg::CRF_CC_EQ:     o_cc_true = z;
      crf_pkg::CRF_CC_NE:     o_cc_true = !z;
      crf_pkg::CRF_CC_MI:     o_cc_true = n;
      crf_pkg::CRF_CC_PL:     o_cc_true = !n;
      crf_pkg::CRF_CC_VS:     o_cc_true = v;
      crf_pkg::CRF_CC_VC:     o_cc_true = !v;
      crf_pkg::CRF_CC_GE:     o_cc_true = !(n ^ v);
      crf_pkg::CRF_CC_LT:     o_cc_true = n ^ v;
      crf_pkg::CRF_CC_GT:     o_cc_true = !(z | (n ^ v));
      crf_pkg::CRF_CC_LE:     o_cc_true = z | (n ^ v);
      crf_pkg::CRF_CC_HI:     o_cc_true = !(c | z);
      crf_pkg::CRF_CC_LS:     o_cc_true = c | z;
    endcase
  end

  // Low flags have no reset value, so the keep check waits until software loads them
  logic flags_loaded_r;
  always_ff @(posedge i_clk) begin
    flags_loaded_r <= !i_rst && (flags_loaded_r || (i_op_valid &&
                      (i_op == crf_pkg::CRF_OP_FLDC || i_op == crf_pkg::CRF_OP_FPOP)));
  end

  a_mask_reset: assert property (@(posedge i_clk) i_rst |=> flags_r[7]) // RULE_06
    else $error("mask flag not set after reset");
  a_irq_block: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_05
    (flags_r[7] && !i_nmi) |-> !o_int_take)
    else $error("maskable interrupt passed while masked");
  a_ip_even: assert property (@(posedge i_clk) disable iff (i_rst) !ip_r[0]) // RULE_04
    else $error("instruction pointer odd");
  a_word_addr: assert property (@(posedge i_clk) i_word_access |-> !o_mem_addr[0]) // RULE_18
    else $error("word access address odd");
  a_zero_flag: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_11
    (i_op_valid && i_op == crf_pkg::CRF_OP_ADDB && !i_int_enter)
    |=> flags_r[2] == ($past(sum8[7:0]) == 8'h00))
    else $error("zero flag wrong after byte add");
  a_half_word: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_09
    (i_op_valid && i_op == crf_pkg::CRF_OP_ADDW) |=> flags_r[5] == $past(sum12[12]))
    else $error("half carry wrong after word add");
  a_flag_keep: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_25
    (!i_op_valid && flags_loaded_r) |=> flags_r[6:0] == $past(flags_r[6:0]))
    else $error("flags changed without operation");
  a_push_copy: assert property (@(posedge i_clk) // RULE_19
    o_flag_push[15:8] == o_flag_push[7:0] && o_flag_push[7:0] == o_flags)
    else $error("stacked flag word not two copies");
  a_int_mask: assert property (@(posedge i_clk) disable iff (i_rst) i_int_enter |=> flags_r[7]) // RULE_06
    else $error("mask not set on interrupt entry");
  a_add_done: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_24
    (i_op_valid && busy_r == 2'h0) |-> ##[1:4] done_r)
    else $error("add not complete in time");
  c_irq_taken: cover property (@(posedge i_clk) i_irq && o_int_take);
  c_nmi_masked: cover property (@(posedge i_clk) i_nmi && flags_r[7]);
  c_daa: cover property (@(posedge i_clk) i_op_valid && i_op == crf_pkg::CRF_OP_DAA);
  c_branch: cover property (@(posedge i_clk) i_cc == crf_pkg::CRF_CC_GT && o_cc_true);
endmodule : crf_core_state
`default_nettype wire

// [core/crf_map.svh]
// Purpose: Constants for the CPU register and flag state block.
// Assumes: Byte-wide flag register, sixteen byte / eight word general registers.
// Notes:   Bit positions and timing counts live here; types live in crf_pkg.
// Operation
// RULE_01: Word registers also accessible as two bytes
// RULE_02: Address from register uses full sixteen bits
// RULE_03: Top word register doubles as stack pointer
// RULE_04: Instruction pointer bit zero always reads zero
// RULE_05: Mask flag blocks all but non-maskable interrupt
// RULE_06: Mask flag set on reset and interrupt entry
// RULE_07: Flag bits six and four are user bits
// RULE_08: Byte arithmetic half-carry from bit three
// RULE_09: Word arithmetic half-carry from bit eleven
// RULE_10: Negative flag copies result sign bit
// RULE_11: Zero flag set when result is zero
// RULE_12: Overflow flag set on arithmetic overflow
// RULE_13: Carry flag: arithmetic carry, shift-out, bit accumulator
// RULE_14: Flag load, store, and, or, xor ops
// RULE_15: Branch conditions use negative, zero, overflow, carry
// RULE_16: Reset loads pointer from vector, sets mask only
// RULE_17: Software sets stack pointer first after reset
// RULE_18: Word access forces address bit zero low
// RULE_19: Flag stacked twice as word, low byte ignored
// RULE_20: Bit operations select bit zero to seven
// RULE_21: Decimal adjust treats each nibble as digit
// RULE_22: Only listed operations use word operands
// RULE_23: Flat address space of 64 kbytes
// RULE_24: Register add and subtract finish within 125 ns
// RULE_25: Untouched flags keep their previous value
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

`define CRF_FLAG_MASK     7
`define CRF_FLAG_USER6    6
`define CRF_FLAG_HALF     5
`define CRF_FLAG_USER4    4
`define CRF_FLAG_NEG      3
`define CRF_FLAG_ZERO     2
`define CRF_FLAG_OVF      1
`define CRF_FLAG_CARRY    0
`define CRF_MASK_RESET    1'h1
`define CRF_STACK_IDX     3'h7
`define CRF_ADD_TIME_NS   125
`define CRF_CLK_PERIOD_NS 25
`define CRF_ADD_CYCLES    (`CRF_ADD_TIME_NS / `CRF_CLK_PERIOD_NS)

`endif

// [core/crf_pkg.sv]
// Purpose: Types for the CPU register and flag state block.
// Assumes: Operation codes are issued by an external decoder.
// Notes:   Encodings are local to this block.
package crf_pkg;
  typedef enum logic [4:0] {
    CRF_OP_NONE   = 5'h00,
    CRF_OP_ADDB   = 5'h01,
    CRF_OP_ADDXB  = 5'h02,
    CRF_OP_SUBB   = 5'h03,
    CRF_OP_SUBXB  = 5'h04,
    CRF_OP_CMPB   = 5'h05,
    CRF_OP_NEGB   = 5'h06,
    CRF_OP_ADDW   = 5'h07,
    CRF_OP_SUBW   = 5'h08,
    CRF_OP_CMPW   = 5'h09,
    CRF_OP_ANDB   = 5'h0A,
    CRF_OP_ORB    = 5'h0B,
    CRF_OP_XORB   = 5'h0C,
    CRF_OP_SHLB   = 5'h0D,
    CRF_OP_SHRB   = 5'h0E,
    CRF_OP_MOVB   = 5'h0F,
    CRF_OP_MOVW   = 5'h10,
    CRF_OP_FLDC   = 5'h11,
    CRF_OP_FAND   = 5'h12,
    CRF_OP_FOR    = 5'h13,
    CRF_OP_FXOR   = 5'h14,
    CRF_OP_BLD    = 5'h15,
    CRF_OP_DAA    = 5'h16,
    CRF_OP_DAS    = 5'h17,
    CRF_OP_ADD_SMALL_CONSTANT_OP   = 5'h18,
    CRF_OP_SUB_SMALL_CONSTANT_OP   = 5'h19,
    CRF_OP_FPOP   = 5'h1A
  } crf_op_t;

  typedef enum logic [3:0] {
    CRF_CC_ALWAYS = 4'h0,
    CRF_CC_NEVER  = 4'h1,
    CRF_CC_CS     = 4'h2,
    CRF_CC_CC     = 4'h3,
    CRF_CC_EQ     = 4'h4,
    CRF_CC_NE     = 4'h5,
    CRF_CC_MI     = 4'h6,
    CRF_CC_PL     = 4'h7,
    CRF_CC_VS     = 4'h8,
    CRF_CC_VC     = 4'h9,
    CRF_CC_GE     = 4'hA,
    CRF_CC_LT     = 4'hB,
    CRF_CC_GT     = 4'hC,
    CRF_CC_LE     = 4'hD,
    CRF_CC_HI     = 4'hE,
    CRF_CC_LS     = 4'hF
  } crf_cc_t;

  typedef enum logic [1:0] {
    CRF_ST_RESET = 2'h0,
    CRF_ST_RUN   = 2'h1,
    CRF_ST_ADD   = 2'h2
  } crf_state_t;
endpackage : crf_pkg

// [core/crf_word_reg.sv]
// Purpose: One word general register with independent byte write lanes.
// Assumes: Byte enables select high and low halves.
// Notes:   No reset: contents are left undefined after reset.
`timescale 1ns/100ps
`default_nettype none
module crf_word_reg (
  input  wire logic        i_clk,
  input  wire logic        i_we_hi,
  input  wire logic        i_we_lo,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_q
);
  logic [7:0] hi_r;
  logic [7:0] lo_r;

  always_ff @(posedge i_clk) begin
    if (i_we_hi) begin
      hi_r <= i_wdata[15:8]; // RULE_01
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_we_lo) begin
      lo_r <= i_wdata[7:0]; // RULE_01
    end
  end

  assign o_q = {hi_r, lo_r};
endmodule : crf_word_reg
`default_nettype wire

// [tb/crf_mem_model.sv]
// Purpose: Word memory on the far side of the core's address port.
// Assumes: Only whole-word stack accesses reach it.
// Notes:   Read data is inverted stale data while no read is enabled.
`timescale 1ns/100ps
`default_nettype none
module crf_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);
  logic [15:0] mem_r [0:255];
  logic [15:0] last_r;
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_addr[8:1]] <= i_wdata;
    end
    if (i_re) begin
      last_r <= mem_r[i_addr[8:1]];
    end
  end
  // Idle reads must never resemble valid data
  assign o_rdata = i_re ? mem_r[i_addr[8:1]] : ~last_r;
endmodule : crf_mem_model
`default_nettype wire

// [tb/tb.sv]
// Purpose: Self-checking bench for the register and flag state block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Flag rows run in order; each row starts from the flags left by the last.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [4:0]  op;
    logic [15:0] a;
    logic [15:0] b;
    logic        so;
    logic [2:0]  bs;
    logic [7:0]  m;
    logic [7:0]  e;
  } crf_row_t;
  logic i_clk, i_rst, i_rd_word, i_wr_en, i_wr_word, i_word_access, i_ip_load, i_ip_step;
  logic i_op_valid, i_shift_out, i_irq, i_nmi, i_int_enter, o_op_done, o_int_take, o_cc_true;
  logic mem_we, mem_re;
  logic [3:0] i_rd_sel, i_wr_sel;
  logic [2:0] i_addr_sel, i_bit_sel;
  logic [15:0] i_wr_data, i_mem_addr, i_vector, i_ip_value, i_opa, i_opb, d;
  logic [15:0] o_rd_data, o_addr, o_stack_top, o_mem_addr, o_ip, o_flag_push, rdata;
  logic [7:0] o_dec_result, o_flags;
  crf_pkg::crf_op_t i_op;
  crf_pkg::crf_cc_t i_cc;
  int err_count, total_checks, cycles, n;
  crf_row_t rows [0:21] = '{
    '{5'h11,16'h0000,16'h0000,1'h0,3'h0,8'hFF,8'h00},
    '{5'h01,16'h007F,16'h0001,1'h0,3'h0,8'hFF,8'h2A},
    '{5'h01,16'h00FF,16'h0001,1'h0,3'h0,8'hFF,8'h25},
    '{5'h02,16'h0000,16'h0000,1'h0,3'h0,8'hFF,8'h00},
    '{5'h03,16'h0010,16'h0001,1'h0,3'h0,8'hFF,8'h20},
    '{5'h05,16'h0005,16'h0005,1'h0,3'h0,8'hFF,8'h04},
    '{5'h04,16'h0003,16'h0001,1'h0,3'h0,8'hFF,8'h00},
    '{5'h06,16'h0001,16'h0001,1'h0,3'h0,8'hFF,8'h29},
    '{5'h07,16'h0FFF,16'h0001,1'h0,3'h0,8'hFF,8'h20},
    '{5'h08,16'h0000,16'h0001,1'h0,3'h0,8'hFF,8'h29},
    '{5'h09,16'h8000,16'h0001,1'h0,3'h0,8'hFF,8'h22},
    '{5'h18,16'h0000,16'h0001,1'h0,3'h0,8'hFF,8'h22},
    '{5'h19,16'h0000,16'h0001,1'h0,3'h0,8'hFF,8'h22},
    '{5'h13,16'h5050,16'h5050,1'h0,3'h0,8'hFF,8'h72},
    '{5'h12,16'hEFEF,16'hEFEF,1'h0,3'h0,8'hFF,8'h62},
    '{5'h14,16'h8080,16'h8080,1'h0,3'h0,8'hFF,8'hE2},
    '{5'h0F,16'h0080,16'h0080,1'h0,3'h0,8'hFF,8'hE8},
    '{5'h15,16'h0020,16'h0020,1'h0,3'h5,8'h01,8'h01},
    '{5'h15,16'h0020,16'h0020,1'h0,3'h4,8'h01,8'h00},
    '{5'h0D,16'h0000,16'h0000,1'h1,3'h0,8'h01,8'h01},
    '{5'h0E,16'h0080,16'h0000,1'h0,3'h0,8'hFF,8'hE0},
    '{5'h10,16'h8000,16'h0000,1'h0,3'h0,8'hFF,8'hE8}
  };
  crf_core_state uut (.i_clk, .i_rst, .i_rd_sel, .i_rd_word, .o_rd_data, .i_addr_sel, .o_addr,
    .i_wr_en, .i_wr_sel, .i_wr_word, .i_wr_data, .o_stack_top, .i_word_access, .i_mem_addr,
    .o_mem_addr, .i_vector, .i_ip_load, .i_ip_value, .i_ip_step, .o_ip, .i_op_valid, .i_op,
    .i_opa, .i_opb, .i_shift_out, .i_bit_sel, .o_dec_result, .o_flags, .o_flag_push,
    .o_op_done, .i_irq, .i_nmi, .i_int_enter, .o_int_take, .i_cc, .o_cc_true);
  crf_mem_model mem (.i_clk(i_clk), .i_we(mem_we), .i_re(mem_re), .i_addr(o_mem_addr),
    .i_wdata(o_flag_push), .o_rdata(rdata));
  initial begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic op(input logic [4:0] c, input logic [15:0] a, input logic so,
                    input logic [2:0] bs, input logic [15:0] b);
    @(negedge i_clk);
    i_op_valid = 1'h1;
    i_op = crf_pkg::crf_op_t'(c);
    i_opa = a;
    i_opb = b;
    i_shift_out = so;
    i_bit_sel = bs;
    @(negedge i_clk);
    i_op_valid = 1'h0;
  endtask : op
  task automatic wr(input logic [3:0] s, input logic w, input logic [15:0] v);
    @(negedge i_clk);
    {i_wr_en, i_wr_sel, i_wr_word, i_wr_data} = {1'h1, s, w, v};
    @(negedge i_clk);
    i_wr_en = 1'h0;
  endtask : wr
  task automatic rdc(input logic [3:0] s, input logic w, input logic [15:0] exp);
    i_rd_sel = s;
    i_rd_word = w;
    #1 chk(o_rd_data, exp);
  endtask : rdc
  initial begin
    {i_rd_word, i_wr_en, i_wr_word, i_word_access, i_ip_load, i_ip_step, i_op_valid} = 7'h00;
    {i_shift_out, i_irq, i_nmi, i_int_enter, mem_we, mem_re, i_rd_sel, i_wr_sel} = 14'h0000;
    {i_addr_sel, i_bit_sel, i_wr_data, i_mem_addr, i_ip_value, i_opa, i_opb} = 86'h0;
    i_op = crf_pkg::CRF_OP_NONE;
    i_cc = crf_pkg::CRF_CC_ALWAYS;
    {i_rst, i_vector} = 17'h10C35;
    repeat (10) @(negedge i_clk);
    chk({15'h0000, o_flags[7]}, 16'h0001);
    i_rst = 1'h0;
    repeat (2) @(negedge i_clk);
    chk(o_ip, 16'h0C34);
    wr(4'h7, 1'h1, 16'h0FFE);
    chk(o_stack_top, 16'h0FFE);
    wr(4'h8, 1'h0, 16'h00A5);
    wr(4'h0, 1'h0, 16'h005A);
    rdc(4'h0, 1'h1, 16'h5AA5);
    rdc(4'h8, 1'h0, 16'h00A5);
    rdc(4'h0, 1'h0, 16'h005A);
    #1 chk(o_addr, 16'h5AA5);
    {i_word_access, i_mem_addr} = 17'h10101;
    #1 chk(o_mem_addr, 16'h0100);
    i_word_access = 1'h0;
    #1 chk(o_mem_addr, 16'h0101);
    @(negedge i_clk);
    {i_ip_load, i_ip_value} = 17'h11235;
    @(negedge i_clk);
    {i_ip_load, i_ip_step} = 2'h1;
    chk(o_ip, 16'h1234);
    @(negedge i_clk);
    i_ip_step = 1'h0;
    chk(o_ip, 16'h1236);
    op(5'h01, 16'h0001, 1'h0, 3'h0, 16'h0001);
    for (n = 0; n < 8 && o_op_done !== 1'h1; n++) @(negedge i_clk);
    chk(16'(n), 16'h0003);
    foreach (rows[k]) begin
      op(rows[k].op, rows[k].a, rows[k].so, rows[k].bs, rows[k].b);
      chk({8'h00, o_flags & rows[k].m}, {8'h00, rows[k].e});
    end
    op(5'h01, 16'h0009, 1'h0, 3'h0, 16'h0001);
    op(5'h16, 16'h000A, 1'h0, 3'h0, 16'h000A);
    chk({8'h00, o_dec_result}, 16'h0010);
    op(5'h03, 16'h0010, 1'h0, 3'h0, 16'h0001);
    op(5'h17, 16'h000F, 1'h0, 3'h0, 16'h000F);
    chk({8'h00, o_dec_result}, 16'h0009);
    for (int j = 0; j < 2; j++) begin
      op(5'h11, j ? 16'h0909 : 16'h0404, 1'h0, 3'h0, 16'h0000);
      d = j ? 16'hAA65 : 16'hA699;
      for (int k = 0; k < 16; k++) begin
        i_cc = crf_pkg::crf_cc_t'(k[3:0]);
        #1 chk({15'h0000, o_cc_true}, {15'h0000, d[k]});
      end
    end
    op(5'h11, 16'h8080, 1'h0, 3'h0, 16'h0000);
    i_irq = 1'h1;
    #1 chk({15'h0000, o_int_take}, 16'h0000);
    i_nmi = 1'h1;
    #1 chk({15'h0000, o_int_take}, 16'h0001);
    i_nmi = 1'h0;
    op(5'h11, 16'h0000, 1'h0, 3'h0, 16'h0000);
    chk({15'h0000, o_int_take}, 16'h0001);
    i_irq = 1'h0;
    i_int_enter = 1'h1;
    @(negedge i_clk);
    i_int_enter = 1'h0;
    chk({15'h0000, o_flags[7]}, 16'h0001);
    op(5'h11, 16'hC3C3, 1'h0, 3'h0, 16'h0000);
    chk(o_flag_push, 16'hC3C3);
    {i_word_access, i_mem_addr, mem_we} = 18'h201E3;
    @(negedge i_clk);
    {mem_we, mem_re} = 2'h1;
    #1 d = rdata;
    op(5'h11, 16'h0000, 1'h0, 3'h0, 16'h0000);
    op(5'h1A, {d[15:8], ~d[7:0]}, 1'h0, 3'h0, 16'h0000);
    mem_re = 1'h0;
    chk({8'h00, o_flags}, 16'h00C3);
    {i_rst, i_vector} = 17'h12001;
    @(negedge i_clk);
    i_rst = 1'h0;
    chk({15'h0000, o_flags[7]}, 16'h0001);
    repeat (2) @(negedge i_clk);
    chk(o_ip, 16'h2000);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
